// ==== logic/port_b_ctrl.sv ====
// Four-bit I/O port with override logic and register port
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
module port_b_ctrl #(
    parameter int PIN_COUNT = 4
) (
    // Clock, reset, enable
    input  wire logic                           ref_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           clk_en_i,
    // Register port
    input  wire logic [port_b_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [port_b_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic      [port_b_pkg::DATA_W-1:0]  reg_rdata_o,
    // Pins
    input  wire logic [port_b_pkg::PINS-1:0]    pin_in_i,
    output logic      [port_b_pkg::PINS-1:0]    pin_out_o,
    output logic      [port_b_pkg::PINS-1:0]    pin_oe_o,
    output logic      [port_b_pkg::PINS-1:0]    pin_pullup_o,
    output logic      [port_b_pkg::PINS-1:0]    pin_dig_in_en_o,
    output logic      [port_b_pkg::PINS-1:0]    pin_dig_in_o,
    // Port-wide controls
    output logic                                bbm_eight_bit_port_o,
    output logic                                strong_sink_pin7_o,
    output logic                                strong_sink_pin5_o,
    // Alternate-function sources
    input  wire logic                           outside_clock_selected_i,
    input  wire logic                           crystal_selected_i,
    input  wire logic                           deep_sleep_active_i,
    input  wire logic                           pin_change_src_zero_i,
    input  wire logic                           pin_change_src_one_i,
    input  wire logic                           pin_change_src_two_i,
    input  wire logic                           pin_change_src_three_i,
    input  wire logic                           pin_change_group_en_i,
    input  wire logic                           analog_ch_zero_dig_off_i,
    input  wire logic                           analog_ch_one_dig_off_i,
    input  wire logic                           analog_ch_two_dig_off_i,
    input  wire logic                           analog_ch_three_dig_off_i,
    input  wire logic                           clock_out_en_i,
    input  wire logic                           system_clock_i,
    input  wire logic                           compare_ch7_out_en_i,
    input  wire logic                           compare_ch7_wave_i,
    input  wire logic                           serial0_rx_en_i,
    input  wire logic                           serial0_remap_i,
    input  wire logic                           serial0_frame_detect_en_i,
    input  wire logic                           ext_irq_zero_en_i,
    input  wire logic                           reset_pin_disable_i
);
    import port_b_pkg::*;

    // Override network is wired per pin, so no other width can be served
    if (PIN_COUNT != PINS) begin : g_pin_count_check
        $error("port_b_ctrl serves exactly four pins");
    end

    logic [1:0]      control_reg;
    logic [1:0]      hdrive_reg;
    logic [PINS-1:0] pullup_reg;
    logic [PINS-1:0] output_reg;
    logic [PINS-1:0] dir_reg;
    logic [PINS-1:0] dir_shown_reg;
    logic [PINS-1:0] pin_meta_reg;
    logic [PINS-1:0] pin_sync_reg;

    logic [PINS-1:0] pullup_override_en;
    logic [PINS-1:0] pullup_override_val;
    logic [PINS-1:0] direction_override_en;
    logic [PINS-1:0] direction_override_val;
    logic [PINS-1:0] outval_override_en;
    logic [PINS-1:0] outval_override_val;
    logic [PINS-1:0] input_enable_override_en;
    logic [PINS-1:0] input_enable_override_val;
    logic [PINS-1:0] dir_next;
    logic [PINS-1:0] output_next;
    logic [PINS-1:0] eff_dir;
    logic [PINS-1:0] eff_out;
    logic [PINS-1:0] eff_pullup;
    logic [PINS-1:0] eff_dien;
    logic            remap_rx;
    logic            ext_clk_or_osc;

    function automatic logic [PINS-1:0] pick(input logic [PINS-1:0] en, input logic [PINS-1:0] ov,
                                             input logic [PINS-1:0] rv);
        pick = (en & ov) | (~en & rv);
    endfunction : pick

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        wr_hit = reg_wr_i && (a == target);
    endfunction : wr_hit

    // Override network per pin
    always_comb begin
        remap_rx       = serial0_rx_en_i & serial0_remap_i;
        ext_clk_or_osc = outside_clock_selected_i | crystal_selected_i;
        pullup_override_en   = {reset_pin_disable_i, clock_out_en_i, crystal_selected_i, ext_clk_or_osc};
        pullup_override_val  = {1'b1, 3'h0};
        direction_override_en  = {reset_pin_disable_i, clock_out_en_i | remap_rx,
                                  crystal_selected_i, ext_clk_or_osc};
        direction_override_val = {1'b0, clock_out_en_i, 2'h0};
        outval_override_en   = {reset_pin_disable_i, compare_ch7_out_en_i | clock_out_en_i,
                                crystal_selected_i, ext_clk_or_osc};
        outval_override_val  = {1'b0, clock_out_en_i ? system_clock_i : compare_ch7_wave_i, 2'h0};
        input_enable_override_en[0] = ext_clk_or_osc | (pin_change_src_zero_i & pin_change_group_en_i)
                                      | analog_ch_zero_dig_off_i;
        input_enable_override_val[0] = (outside_clock_selected_i & deep_sleep_active_i)
                                       | (outside_clock_selected_i & crystal_selected_i
                                          & pin_change_src_zero_i & pin_change_group_en_i);
        input_enable_override_en[1] = crystal_selected_i | (pin_change_src_one_i & pin_change_group_en_i)
                                      | analog_ch_one_dig_off_i;
        input_enable_override_val[1] = crystal_selected_i | (pin_change_src_one_i & pin_change_group_en_i);
        input_enable_override_val[2] = (pin_change_src_two_i & pin_change_group_en_i) | ext_irq_zero_en_i
                                       | (remap_rx & serial0_frame_detect_en_i);
        input_enable_override_en[2] = input_enable_override_val[2] | analog_ch_two_dig_off_i;
        input_enable_override_en[3] = (pin_change_src_three_i & pin_change_group_en_i)
                                      | analog_ch_three_dig_off_i | reset_pin_disable_i;
        input_enable_override_val[3] = pin_change_src_three_i & pin_change_group_en_i
                                       & reset_pin_disable_i;
    end

    // Effective pin controls
    always_comb begin
        eff_pullup = pick(pullup_override_en, pullup_override_val, pullup_reg);
        eff_dir    = pick(direction_override_en, direction_override_val, dir_shown_reg);
        eff_out    = pick(outval_override_en, outval_override_val, output_reg);
        eff_dien   = pick(input_enable_override_en, input_enable_override_val, {PINS{1'b1}});
    end

    // Register next values
    always_comb begin
        dir_next    = dir_reg;
        output_next = output_reg;
        if (wr_hit(reg_addr_i, ADDR_DIR)) begin
            dir_next = reg_wdata_i[PINS-1:0];
        end
        if (wr_hit(reg_addr_i, ADDR_OUTPUT)) begin
            output_next = reg_wdata_i[PINS-1:0];
        end else if (wr_hit(reg_addr_i, ADDR_INPUT)) begin
            output_next = output_reg ^ reg_wdata_i[PINS-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            control_reg <= RST_CTRL2;
            hdrive_reg  <= RST_CTRL2;
            pullup_reg  <= RST_PORT4;
            output_reg  <= RST_PORT4;
            dir_reg     <= RST_PORT4;
        end else if (clk_en_i) begin
            if (wr_hit(reg_addr_i, ADDR_CONTROL)) begin
                control_reg <= reg_wdata_i[1:0];
            end
            if (wr_hit(reg_addr_i, ADDR_HDRIVE)) begin
                hdrive_reg <= reg_wdata_i[1:0];
            end
            if (wr_hit(reg_addr_i, ADDR_PULLUP)) begin
                pullup_reg <= reg_wdata_i[PINS-1:0];
            end
            output_reg <= output_next;
            dir_reg    <= dir_next;
        end
    end

    // Break-before-make: a rising direction bit waits one cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            dir_shown_reg <= RST_PORT4;
        end else if (clk_en_i) begin
            if (control_reg[BIT_BBM_B]) begin
                dir_shown_reg <= dir_reg & dir_next;
            end else begin
                dir_shown_reg <= dir_next;
            end
        end
    end

    // Pins are asynchronous to the clock, so two stages
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_meta_reg <= RST_PORT4;
            pin_sync_reg <= RST_PORT4;
        end else if (clk_en_i) begin
            pin_meta_reg <= pin_in_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Registered pin drive
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_out_o       <= RST_PORT4;
            pin_oe_o        <= RST_PORT4;
            pin_pullup_o    <= RST_PORT4;
            pin_dig_in_en_o <= RST_PORT4;
            pin_dig_in_o    <= RST_PORT4;
            bbm_eight_bit_port_o <= 1'b0;
            strong_sink_pin7_o   <= 1'b0;
            strong_sink_pin5_o   <= 1'b0;
        end else if (clk_en_i) begin
            pin_oe_o        <= eff_dir;
            pin_out_o       <= eff_out & eff_dir;
            pin_pullup_o    <= eff_pullup & ~eff_dir;
            pin_dig_in_en_o <= eff_dien;
            // Gated input held low so idle pins do not float into logic
            pin_dig_in_o    <= (pin_sync_reg & eff_dien) | (input_enable_override_en & input_enable_override_val);
            bbm_eight_bit_port_o <= control_reg[BIT_BBM_A];
            strong_sink_pin7_o   <= hdrive_reg[BIT_SINK_PIN7];
            strong_sink_pin5_o   <= hdrive_reg[BIT_SINK_PIN5];
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                if (reg_addr_i == ADDR_CONTROL) begin
                    reg_rdata_o <= {6'h00, control_reg};
                end else if (reg_addr_i == ADDR_HDRIVE) begin
                    reg_rdata_o <= {6'h00, hdrive_reg};
                end else if (reg_addr_i == ADDR_PULLUP) begin
                    reg_rdata_o <= {4'h0, pullup_reg};
                end else if (reg_addr_i == ADDR_OUTPUT) begin
                    reg_rdata_o <= {4'h0, output_reg};
                end else if (reg_addr_i == ADDR_DIR) begin
                    reg_rdata_o <= {4'h0, dir_reg};
                end else if (reg_addr_i == ADDR_INPUT) begin
                    reg_rdata_o <= {4'h0, pin_sync_reg};
                end else begin
                    reg_rdata_o <= 8'h00;
                end
            end
        end
    end
endmodule : port_b_ctrl

// ==== logic/port_b_pkg.sv ====
// Constants for the four-bit port with alternate-function overrides
// Functional notes
// - Pin 0 outside clock or crystal: pull-up off, input, output zero.
// - Pin 0 input enable override: outside clock or crystal, enabled pin-change, or analog off.
// - Pin 0 input override true: sleep on outside clock, or clock, crystal, pin-change.
// - Pin 1 crystal: pull-up off, input, zero; input override by crystal, pin-change, analog.
// - Pin 1 input override true on crystal or enabled pin-change source.
// - Pin 2 direction override by clock out or remapped receiver; value is clock out.
// - Pin 2 output override by compare or clock out; drives clock or compare wave.
// - Pin 2 input override from pin-change, irq zero, remapped receiver frame detect, analog.
// - Pin 3 reset disabled: pull-up on, input, output zero.
// - Pin 3 input override true when pin-change, group enable and reset disable set.
// - Control bit 1 break-before-make for four-bit port, bit 0 for eight-bit port.
// - Break-before-make: switch to output passes one tri-state cycle first.
// - High-drive bit 1 strengthens pin seven sink, bit 0 pin five.
// - Reserved upper register bits always read zero.
// - Set pull-up bit enables that pin's pull-up; here only while the pin is an input.
// - Output pin drives high for set output bit, low for cleared.
// - Input pin ignores its output register bit.
// - Set direction bit makes pin output, cleared makes input.
// - Input register reads pin levels; writing one toggles output bit.
package port_b_pkg;
    localparam int          ADDR_W        = 3;
    localparam int          DATA_W        = 8;
    localparam int          PINS          = 4;
    localparam logic [2:0]  ADDR_CONTROL  = 3'h0;
    localparam logic [2:0]  ADDR_HDRIVE   = 3'h1;
    localparam logic [2:0]  ADDR_PULLUP   = 3'h2;
    localparam logic [2:0]  ADDR_OUTPUT   = 3'h3;
    localparam logic [2:0]  ADDR_DIR      = 3'h4;
    localparam logic [2:0]  ADDR_INPUT    = 3'h5;
    localparam int          BIT_BBM_B     = 1;
    localparam int          BIT_BBM_A     = 0;
    localparam int          BIT_SINK_PIN7 = 1;
    localparam int          BIT_SINK_PIN5 = 0;
    localparam logic [1:0]  RST_CTRL2     = 2'h0;
    localparam logic [3:0]  RST_PORT4     = 4'h0;
endpackage : port_b_pkg

// ==== tb/pin_env.sv ====
// Pin environment: device drive, outside drive, pull-up and floating pins
`timescale 1ns/10ps
module pin_env (
    // Clock
    input  wire logic       ref_clk_i,
    // Device side
    input  wire logic [3:0] pin_out_i,
    input  wire logic [3:0] pin_oe_i,
    input  wire logic [3:0] pin_pullup_i,
    // Outside drivers
    input  wire logic [3:0] ext_en_i,
    input  wire logic [3:0] ext_val_i,
    // Resolved level
    output logic      [3:0] pin_lvl_o
);
    // Floating pins wander so a lost drive never reads as stable
    logic [3:0] flip_reg = 4'h5;
    always_ff @(posedge ref_clk_i) begin
        flip_reg <= ~flip_reg;
    end
    assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                     | (~pin_oe_i & ~ext_en_i & (pin_pullup_i | flip_reg));
endmodule : pin_env

// ==== tb/port_b_ctrl_sva.sv ====
// Checker tying the port outputs to their register and alternate-function causes
`timescale 1ns/10ps
module port_b_ctrl_sva (
    // Clock, reset, register port
    input wire logic                          ref_clk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i,
    input wire logic [port_b_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [port_b_pkg::DATA_W-1:0] reg_wdata_i, reg_rdata_o,
    // Pins
    input wire logic [port_b_pkg::PINS-1:0]   pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o, pin_dig_in_o,
    // Port-wide controls and sources
    input wire logic                          bbm_eight_bit_port_o, strong_sink_pin7_o, crystal_selected_i,
    input wire logic                          clock_out_en_i, system_clock_i, compare_ch7_out_en_i,
    input wire logic                          compare_ch7_wave_i, reset_pin_disable_i
);
    import port_b_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_xtal_pin_zero: assert property (clk_en_i && crystal_selected_i |=>
        !pin_oe_o[0] && !pin_out_o[0] && !pin_pullup_o[0]) else $error("pin 0 kept on crystal");
    a_xtal_pin_one: assert property (clk_en_i && crystal_selected_i |=>
        !pin_oe_o[1] && !pin_out_o[1] && !pin_pullup_o[1] && pin_dig_in_o[1]) else $error("pin 1 kept on crystal");
    a_rstdis_pin_three: assert property (clk_en_i && reset_pin_disable_i |=>
        pin_pullup_o[3] && !pin_oe_o[3] && !pin_out_o[3]) else $error("pin 3 not forced");
    a_clkout_drive: assert property (clk_en_i && clock_out_en_i |=>
        pin_oe_o[2] && !pin_pullup_o[2] && pin_out_o[2] == $past(system_clock_i)) else $error("clock out wrong");
    a_compare_drive: assert property (clk_en_i && compare_ch7_out_en_i && !clock_out_en_i |=>
        !pin_oe_o[2] || pin_out_o[2] == $past(compare_ch7_wave_i)) else $error("compare wave wrong");
    a_resv_ctrl_zero: assert property (clk_en_i && reg_rd_i && reg_addr_i < ADDR_PULLUP |=>
        reg_rdata_o[7:2] == 6'h00) else $error("control reserved bits set");
    a_resv_port_zero: assert property (clk_en_i && reg_rd_i |=> reg_rdata_o[7:4] == 4'h0)
        else $error("port reserved bits set");
    a_pin_readback: assert property (clk_en_i && reg_rd_i && reg_addr_i == ADDR_INPUT && !$past(sys_rst_i, 2)
        && $stable(pin_in_i) && $past(pin_in_i, 2) == pin_in_i |=> reg_rdata_o[3:0] == $past(pin_in_i))
        else $error("input read wrong");
    a_sink_follow: assert property (clk_en_i && reg_wr_i && reg_addr_i == ADDR_HDRIVE ##1 clk_en_i |=>
        strong_sink_pin7_o == $past(reg_wdata_i[BIT_SINK_PIN7], 2)) else $error("sink enable wrong");
    a_bbm_follow: assert property (clk_en_i && reg_wr_i && reg_addr_i == ADDR_CONTROL ##1 clk_en_i |=>
        bbm_eight_bit_port_o == $past(reg_wdata_i[BIT_BBM_A], 2)) else $error("bbm enable wrong");
endmodule : port_b_ctrl_sva

bind port_b_ctrl port_b_ctrl_sva chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_pullup_o, .pin_dig_in_o,
    .bbm_eight_bit_port_o, .strong_sink_pin7_o, .crystal_selected_i, .clock_out_en_i, .system_clock_i,
    .compare_ch7_out_en_i, .compare_ch7_wave_i, .reset_pin_disable_i);

// ==== tb/port_b_ctrl_tb_top.sv ====
// Self-checking bench for the four-bit port block
`timescale 1ns/10ps
module port_b_ctrl_tb_top;
    import port_b_pkg::*;
    localparam logic [20:0] XTAL = 21'h1, OCLK = 21'h2, SLEEP = 21'h4, GRP = 21'h8, CLOCK_OUT_EN = 21'h10;
    localparam logic [20:0] SCLK = 21'h20, CMP = 21'h40, WAVE = 21'h80, RX = 21'h700, IRQ = 21'h800;
    localparam logic [20:0] RDIS = 21'h1000, PC = 21'h1E000, AN = 21'h1E0000;
    logic        ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, bbm8, sink7, sink5;
    logic [2:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o;
    logic [3:0]  pin_lvl, pin_out_o, pin_oe_o, pin_pullup_o, pin_dig_in_o, ext_en, ext_val, dien;
    logic [20:0] src;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0;

    port_b_ctrl dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
        .pin_dig_in_en_o(dien), .pin_dig_in_o(pin_dig_in_o), .bbm_eight_bit_port_o(bbm8),
        .strong_sink_pin7_o(sink7), .strong_sink_pin5_o(sink5), .crystal_selected_i(src[0]),
        .outside_clock_selected_i(src[1]),
        .deep_sleep_active_i(src[2]), .pin_change_group_en_i(src[3]), .clock_out_en_i(src[4]),
        .system_clock_i(src[5]), .compare_ch7_out_en_i(src[6]), .compare_ch7_wave_i(src[7]),
        .serial0_rx_en_i(src[8]), .serial0_remap_i(src[9]), .serial0_frame_detect_en_i(src[10]),
        .ext_irq_zero_en_i(src[11]), .reset_pin_disable_i(src[12]), .pin_change_src_zero_i(src[13]),
        .pin_change_src_one_i(src[14]), .pin_change_src_two_i(src[15]), .pin_change_src_three_i(src[16]),
        .analog_ch_zero_dig_off_i(src[17]), .analog_ch_one_dig_off_i(src[18]),
        .analog_ch_two_dig_off_i(src[19]), .analog_ch_three_dig_off_i(src[20]));
    pin_env env (.ref_clk_i(ref_clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_pullup_i(pin_pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pin_lvl));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Whole run needs about a hundred cycles
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Strobe left high so writes can run back to back; next task drops it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(reg_rdata_o, e);
    endtask : rd

    // Sources and outside drive set, then pins and pull-up/input masked compare
    task automatic ovr(input logic [20:0] v, input logic [7:0] x, input int n, input logic [7:0] e1, e2, m);
        @(posedge ref_clk_i);
        src <= v;
        {ext_en, ext_val} <= x;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk({pin_oe_o, pin_out_o}, e1);
        chk({pin_pullup_o, pin_dig_in_o} & m, e2);
    endtask : ovr

    initial begin
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, src, ext_en, ext_val} = '0;
        // Outside drive holds pins low so the first input read is defined
        ext_en = 4'hF;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), 8'h00);
        end
        for (int i = 0; i < 5; i++) begin
            wr(3'(i), 8'hFF);
            rd(3'(i), (i < 2) ? 8'h03 : 8'h0F);
        end
        wr(3'h6, 8'hFF);
        rd(3'h6, 8'h00);
        ovr(0, 8'h00, 3, 8'hFF, 8'h0F, 8'hFF);
        chk({5'h0, bbm8, sink7, sink5}, 8'h07);
        rd(ADDR_INPUT, 8'h0F);
        wr(ADDR_INPUT, 8'h05);
        ovr(0, 8'h00, 1, 8'hFA, 8'h00, 8'hF0);
        wr(ADDR_DIR, 8'h00);
        ovr(0, 8'h32, 4, 8'h00, 8'hFE, 8'hFF);
        rd(ADDR_INPUT, 8'h0E);
        wr(ADDR_DIR, 8'h01);
        ovr(0, 8'h32, 1, 8'h00, 8'h00, 8'h00);
        ovr(0, 8'h32, 0, 8'h10, 8'h00, 8'h00);
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_DIR, 8'h00);
        wr(ADDR_DIR, 8'h01);
        ovr(0, 8'h32, 1, 8'h10, 8'h00, 8'h00);
        chk({7'h0, bbm8}, 8'h01);
        wr(ADDR_DIR, 8'h0F);
        wr(ADDR_OUTPUT, 8'h0F);
        ovr(XTAL, 8'h00, 1, 8'hCC, 8'h02, 8'hF2);
        ovr(OCLK, 8'h00, 1, 8'hEE, 8'h00, 8'hF0);
        ovr(RDIS, 8'h00, 1, 8'h77, 8'h80, 8'hF0);
        wr(ADDR_OUTPUT, 8'h00);
        wr(ADDR_DIR, 8'h00);
        ovr(CLOCK_OUT_EN | SCLK, 8'h00, 1, 8'h44, 8'hB0, 8'hF0);
        ovr(CLOCK_OUT_EN, 8'h00, 1, 8'h40, 8'hB0, 8'hF0);
        wr(ADDR_DIR, 8'h04);
        ovr(CMP | WAVE, 8'hF0, 1, 8'h44, 8'hB0, 8'hF0);
        ovr(CMP, 8'hF0, 3, 8'h40, 8'hB0, 8'hF0);
        ovr(RX, 8'hF0, 1, 8'h00, 8'hF4, 8'hFF);
        wr(ADDR_DIR, 8'h00);
        ovr(AN, 8'hFF, 3, 8'h00, 8'hF0, 8'hFF);
        chk({4'h0, dien}, 8'h00);
        ovr(AN | IRQ, 8'hFF, 1, 8'h00, 8'hF4, 8'hFF);
        ovr(PC | GRP, 8'hF0, 3, 8'h00, 8'hF6, 8'hFF);
        chk({4'h0, dien}, 8'h06);
        ovr(PC | GRP | OCLK | SLEEP, 8'hF0, 1, 8'h00, 8'hE7, 8'hFF);
        ovr(PC | GRP | RDIS, 8'hF0, 1, 8'h00, 8'hFE, 8'hFF);
        stop_test();
    end
endmodule : port_b_ctrl_tb_top
